// ### ssw_regs.svh
`ifndef SSW_REGS_SVH
`define SSW_REGS_SVH

// ----------------------------------------------------------------------
// Clock and timing constants
// ----------------------------------------------------------------------
`define SSW_CLK_MHZ 100
`define SSW_GLITCH_NS 3000
`define SSW_GLITCH_CYC (`SSW_GLITCH_NS * `SSW_CLK_MHZ / 1000)
`define SSW_TD_MS 25
`define SSW_TD_CYC (`SSW_TD_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_TOUT_GND_MS 250
`define SSW_TOUT_GND_CYC (`SSW_TOUT_GND_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_TOUT_VDD_MS 2500
`define SSW_TOUT_VDD_CYC (`SSW_TOUT_VDD_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_CAP_UNIT_US 6250
`define SSW_CAP_UNIT_CYC (`SSW_CAP_UNIT_US * `SSW_CLK_MHZ)

// ----------------------------------------------------------------------
// Window ratios in tenths (upper / lower)
// ----------------------------------------------------------------------
`define SSW_RAT_GND_R0 318
`define SSW_RAT_VDD_R0 320
`define SSW_RAT_CAP_R0 258
`define SSW_RAT_GND_R1 1249
`define SSW_RAT_VDD_R1 1277
`define SSW_RAT_CAP_R1 645

// Cap code strap width and reset value of the open-drain enable
`define SSW_CAP_CODE_W 12
`define SSW_OE_N_RST 1'b0

`endif

// ### ssw_pkg.sv
package ssw_pkg;
    typedef enum logic [1:0] {SSW_ST_HOLD, SSW_ST_DELAY, SSW_ST_RUN} ssw_state_e;
    typedef enum logic [1:0] {SSW_TM_GND, SSW_TM_VDD, SSW_TM_CAP, SSW_TM_BAD} ssw_tmode_e;
    typedef logic [31:0] ssw_cnt_t;
endpackage

// ### ssw_supervisor.sv
`timescale 1ns/1ps
`include "ssw_regs.svh"

// Notes on behaviour
// - Drive reset low once supply passes 1.1V
// - Hold reset while supply below trip level
// - Release reset 25 ms after supply recovers
// - Ignore supply excursions shorter than 3 us
// - Timeout pin selects 0.25 s, 2.5 s or (capCode+1) x 6.25 ms
// - Ratio pin low: ratios 31.8, 32, 25.8
// - Ratio pin high: ratios 124.9, 127.7, 64.5
// - Any kick edge services; timeout forces reset
// - Lower bound off until first rising kick
// - Early kick or no kick asserts reset
module ssw_supervisor
    import ssw_pkg::*;
#(
    parameter ssw_cnt_t TD_CYC = `SSW_TD_CYC,
    parameter ssw_cnt_t TOUT_GND_CYC = `SSW_TOUT_GND_CYC,
    parameter ssw_cnt_t TOUT_VDD_CYC = `SSW_TOUT_VDD_CYC,
    parameter ssw_cnt_t CAP_UNIT_CYC = `SSW_CAP_UNIT_CYC,
    parameter ssw_cnt_t LOW_GND_R0 = TOUT_GND_CYC * 10 / `SSW_RAT_GND_R0,
    parameter ssw_cnt_t LOW_VDD_R0 = TOUT_VDD_CYC * 10 / `SSW_RAT_VDD_R0,
    parameter ssw_cnt_t LOW_CAP_R0 = CAP_UNIT_CYC * 10 / `SSW_RAT_CAP_R0,
    parameter ssw_cnt_t LOW_GND_R1 = TOUT_GND_CYC * 10 / `SSW_RAT_GND_R1,
    parameter ssw_cnt_t LOW_VDD_R1 = TOUT_VDD_CYC * 10 / `SSW_RAT_VDD_R1,
    parameter ssw_cnt_t LOW_CAP_R1 = CAP_UNIT_CYC * 10 / `SSW_RAT_CAP_R1
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic supplyPorOk,
    input wire logic supplyAboveTrip,
    input wire logic watchdogKickInput,
    input wire logic [1:0] timeoutSelectPin,
    input wire logic ratioSelectPin,
    input wire logic [`SSW_CAP_CODE_W-1:0] capCode,
    output logic resetPinOut,
    output logic resetPinOeN
);

    localparam logic [8:0] GLITCH_CYC = 9'(`SSW_GLITCH_CYC);
    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic porSync1_ff, porSync2_ff, supSync1_ff, supSync2_ff;
    logic kickSync1_ff, kickSync2_ff, kickPrev_ff;
    logic ratSync1_ff, ratSync2_ff;
    logic [1:0] tmSync1_ff, tmSync2_ff;
    logic [`SSW_CAP_CODE_W-1:0] capSync1_ff, capSync2_ff;
    logic kickEdge, kickRise;

    // Two flops per pin plus a kick history flop, first stage feeds only the second
    always_ff @(posedge sys_clk)
    begin
        porSync1_ff <= supplyPorOk;
        porSync2_ff <= porSync1_ff;
        supSync1_ff <= supplyAboveTrip;
        supSync2_ff <= supSync1_ff;
        kickSync1_ff <= watchdogKickInput;
        kickSync2_ff <= kickSync1_ff;
        kickPrev_ff <= kickSync2_ff;
        ratSync1_ff <= ratioSelectPin;
        ratSync2_ff <= ratSync1_ff;
        tmSync1_ff <= timeoutSelectPin;
        tmSync2_ff <= tmSync1_ff;
        capSync1_ff <= capCode;
        capSync2_ff <= capSync1_ff;
    end

    assign kickEdge = kickSync2_ff ^ kickPrev_ff;
    assign kickRise = kickSync2_ff & ~kickPrev_ff;

    // ------------------------------------------------------------------
    // Supply glitch filter
    // ------------------------------------------------------------------
    logic supFilt_ff, nxt_supFilt;
    logic [8:0] glitchCnt_ff, nxt_glitchCnt;

    always_comb
    begin
        nxt_supFilt = supFilt_ff;
        nxt_glitchCnt = 9'h000;
        if (supSync2_ff != supFilt_ff)
        begin
            if (glitchCnt_ff == GLITCH_CYC - 9'h001)
                nxt_supFilt = supSync2_ff;
            else
                nxt_glitchCnt = glitchCnt_ff + 9'h001;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            supFilt_ff <= 1'b0;
            glitchCnt_ff <= 9'h000;
        end
        else
        begin
            supFilt_ff <= nxt_supFilt;
            glitchCnt_ff <= nxt_glitchCnt;
        end
    end

    // ------------------------------------------------------------------
    // Window limits from straps
    // ------------------------------------------------------------------
    ssw_cnt_t upper_ff, lower_ff, nxt_upper, nxt_lower;
    ssw_cnt_t capUnits;

    always_comb
    begin
        capUnits = ssw_cnt_t'(capSync2_ff) + 32'h0000_0001;
        unique case (ssw_tmode_e'(tmSync2_ff))
            SSW_TM_VDD:
            begin
                nxt_upper = TOUT_VDD_CYC;
                nxt_lower = ratSync2_ff ? LOW_VDD_R1 : LOW_VDD_R0;
            end
            SSW_TM_CAP:
            begin
                nxt_upper = 32'(capUnits * CAP_UNIT_CYC);
                nxt_lower = 32'(capUnits * (ratSync2_ff ? LOW_CAP_R1 : LOW_CAP_R0));
            end
            default:
            begin
                nxt_upper = TOUT_GND_CYC;
                nxt_lower = ratSync2_ff ? LOW_GND_R1 : LOW_GND_R0;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            upper_ff <= TOUT_GND_CYC;
            lower_ff <= LOW_GND_R0;
        end
        else
        begin
            upper_ff <= nxt_upper;
            lower_ff <= nxt_lower;
        end
    end

    // ------------------------------------------------------------------
    // Supervisor state machine and watchdog timer
    // ------------------------------------------------------------------
    ssw_state_e state_ff, nxt_state;
    ssw_cnt_t cnt_ff, nxt_cnt;
    logic lowerEn_ff, nxt_lowerEn, earlyKick;
    logic oeN_ff, nxt_oeN;
    assign earlyKick = lowerEn_ff && (cnt_ff < lower_ff);
    // Next state, service count and lower bound arming
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_lowerEn = lowerEn_ff;
        unique case (state_ff)
            SSW_ST_HOLD:
            begin
                nxt_cnt = 32'h0000_0000;
                if (supFilt_ff)
                    nxt_state = SSW_ST_DELAY;
            end
            SSW_ST_DELAY:
            begin
                if (cnt_ff == TD_CYC - 32'h0000_0001)
                begin
                    nxt_state = SSW_ST_RUN;
                    nxt_cnt = 32'h0000_0000;
                    nxt_lowerEn = 1'b0;
                end
                else
                    nxt_cnt = cnt_ff + 32'h0000_0001;
            end
            SSW_ST_RUN:
            begin
                if (kickEdge)
                begin
                    nxt_cnt = 32'h0000_0000;
                    if (earlyKick)
                        nxt_state = SSW_ST_DELAY;
                    else if (kickRise)
                        nxt_lowerEn = 1'b1;
                end
                else if (cnt_ff >= upper_ff - 32'h0000_0001)
                begin
                    nxt_state = SSW_ST_DELAY;
                    nxt_cnt = 32'h0000_0000;
                end
                else
                    nxt_cnt = cnt_ff + 32'h0000_0001;
            end
        endcase
        if (!supFilt_ff)
        begin
            nxt_state = SSW_ST_HOLD;
            nxt_cnt = 32'h0000_0000;
        end
        nxt_oeN = !porSync2_ff || (nxt_state == SSW_ST_RUN);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_ff <= SSW_ST_HOLD;
            cnt_ff <= 32'h0000_0000;
            lowerEn_ff <= 1'b0;
            oeN_ff <= `SSW_OE_N_RST;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            lowerEn_ff <= nxt_lowerEn;
            oeN_ff <= nxt_oeN;
        end
    end

    // Open-drain: level constant low, enable carries the reset
    always_ff @(posedge sys_clk)
    begin
        resetPinOut <= 1'b0;
    end
    assign resetPinOeN = oeN_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_runKick;
        state_ff == SSW_ST_RUN && supFilt_ff && kickEdge;
    endsequence
    sequence s_toDelay;
        state_ff == SSW_ST_DELAY && cnt_ff == 32'h0000_0000;
    endsequence
    property p_lowWhenNotRun;
        (state_ff != SSW_ST_RUN && $past(porSync2_ff)) |-> !oeN_ff;
    endproperty
    a_lowWhenNotRun: assert property (p_lowWhenNotRun) else $error("reset not driven low");
    property p_supplyLoss;
        $fell(supFilt_ff) |=> state_ff == SSW_ST_HOLD;
    endproperty
    a_supplyLoss: assert property (p_supplyLoss) else $error("supply loss missed");
    property p_delayEnd;
        state_ff == SSW_ST_RUN && $past(state_ff) != SSW_ST_RUN
            |-> $past(cnt_ff) == TD_CYC - 32'h0000_0001;
    endproperty
    a_delayEnd: assert property (p_delayEnd) else $error("release delay wrong");
    property p_glitch;
        $changed(supFilt_ff) |-> $past(glitchCnt_ff) == GLITCH_CYC - 9'h001;
    endproperty
    a_glitch: assert property (p_glitch) else $error("glitch filter too short");
    property p_vddTimeout;
        tmSync2_ff == 2'b01 |=> upper_ff == TOUT_VDD_CYC;
    endproperty
    a_vddTimeout: assert property (p_vddTimeout) else $error("upper limit wrong");
    property p_ratioLow;
        (tmSync2_ff == 2'b00 && !ratSync2_ff) |=> lower_ff == LOW_GND_R0;
    endproperty
    a_ratioLow: assert property (p_ratioLow) else $error("lower limit wrong");
    property p_ratioHigh;
        (tmSync2_ff == 2'b01 && ratSync2_ff) |=> lower_ff == LOW_VDD_R1;
    endproperty
    a_ratioHigh: assert property (p_ratioHigh) else $error("lower limit wrong");
    property p_goodKick;
        (s_runKick and !earlyKick) |=> state_ff == SSW_ST_RUN && cnt_ff == 32'h0000_0000;
    endproperty
    a_goodKick: assert property (p_goodKick) else $error("kick not serviced");
    property p_earlyKick;
        (s_runKick and earlyKick) |=> s_toDelay ##1 !oeN_ff || !porSync2_ff;
    endproperty
    a_earlyKick: assert property (p_earlyKick) else $error("early kick ignored");
    property p_armOff;
        $rose(state_ff == SSW_ST_RUN) |-> !lowerEn_ff;
    endproperty
    a_armOff: assert property (p_armOff) else $error("lower bound armed at release");
endmodule

// ### ssw_kick_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Supervised processor kicking the watchdog
// ----------------------------------------------------------------------
module ssw_kick_model
    import ssw_pkg::*;
(
    input wire logic sys_clk,
    input wire logic kickEn,
    input wire ssw_cnt_t kickPeriod,
    output logic watchdogKickInput = 1'b0
);
    ssw_cnt_t cnt_ff = '0;

    // Toggle once per period; parked low while disabled
    // kick spacing set by kickPeriod
    always_ff @(posedge sys_clk)
    begin
        if (!kickEn)
        begin
            cnt_ff <= '0;
            watchdogKickInput <= 1'b0;
        end
        else if (cnt_ff >= kickPeriod - 1)
        begin
            cnt_ff <= '0;
            watchdogKickInput <= ~watchdogKickInput;
        end
        else
            cnt_ff <= cnt_ff + 1;
    end
endmodule

// ### supply_supervisor_window_watchdog_tb.sv
`timescale 1ns/1ps
`include "ssw_regs.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
    $display("ERROR %s expected %0d seen %0d", nm, ex, got); failures++; end end

module supply_supervisor_window_watchdog_tb
    import ssw_pkg::*;
;
    localparam int TD = 50;
    localparam int TGND = 2000;
    localparam int TVDD = 4000;
    localparam int CAPU = 129;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic supplyPorOk = 1'b0;
    logic supplyAboveTrip = 1'b0;
    logic [1:0] timeoutSelectPin = 2'h0;
    logic ratioSelectPin = 1'b0;
    logic [`SSW_CAP_CODE_W-1:0] capCode = '0;
    logic kickEn = 1'b0;
    ssw_cnt_t kickPeriod = 32'h64;
    logic kick;
    logic resetPinOut;
    logic resetPinOeN;
    int failures = 0;
    int cmp_count = 0;
    int n;

    ssw_supervisor #(.TD_CYC(TD), .TOUT_GND_CYC(TGND), .TOUT_VDD_CYC(TVDD),
        .CAP_UNIT_CYC(CAPU)) dut (.sys_clk(sys_clk), .rst(rst),
        .supplyPorOk(supplyPorOk), .supplyAboveTrip(supplyAboveTrip),
        .watchdogKickInput(kick), .timeoutSelectPin(timeoutSelectPin),
        .ratioSelectPin(ratioSelectPin), .capCode(capCode),
        .resetPinOut(resetPinOut), .resetPinOeN(resetPinOeN));

    ssw_kick_model cpu (.sys_clk(sys_clk), .kickEn(kickEn), .kickPeriod(kickPeriod),
        .watchdogKickInput(kick));

    // Clock
    always #5 sys_clk = ~sys_clk;

    task print_verdict;
        $display("Compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask

    // Bounded wait for the reset pin enable to reach a level
    task wait_oen(input logic v, input int lim, output int cnt);
        cnt = 0;
        while (resetPinOeN !== v)
        begin
            @(posedge sys_clk);
            cnt++;
            if (cnt > lim)
            begin
                $display("ERROR reset pin wait for %0d timed out", v);
                failures++;
                print_verdict;
            end
        end
    endtask

    task hold_oen(input int k, input string nm);
        repeat (k)
        begin
            @(posedge sys_clk);
            `CHK(nm, 1'b1, resetPinOeN)
        end
    endtask

    // Power cycle the trip comparator with new straps
    task restart(input logic [1:0] ts, input logic rs, input int cap);
        kickEn <= 1'b0;
        supplyAboveTrip <= 1'b0;
        cyc(310);
        timeoutSelectPin <= ts;
        ratioSelectPin <= rs;
        capCode <= cap[11:0];
        supplyAboveTrip <= 1'b1;
        wait_oen(1'b1, 400, n);
    endtask

    task t_por;
        `CHK("oen in reset", 1'b0, resetPinOeN)
        rst <= 1'b0;
        cyc(6);
        `CHK("oen below por", 1'b1, resetPinOeN)
        supplyPorOk <= 1'b1;
        cyc(4);
        `CHK("oen above por", 1'b0, resetPinOeN)
        `CHK("pin level", 1'b0, resetPinOut)
    endtask

    task t_power_up;
        supplyAboveTrip <= 1'b1;
        wait_oen(1'b1, 400, n);
        `CHK("release delay", 1'b1, n >= 300 + TD && n <= 308 + TD)
    endtask

    task t_glitch;
        kickEn <= 1'b1;
        cyc(150);
        supplyAboveTrip <= 1'b0;
        cyc(200);
        supplyAboveTrip <= 1'b1;
        hold_oen(400, "short dip");
        supplyAboveTrip <= 1'b0;
        wait_oen(1'b0, 320, n);
        `CHK("dip to reset", 1'b1, n >= 300 && n <= 306)
        kickEn <= 1'b0;
        supplyAboveTrip <= 1'b1;
        wait_oen(1'b1, 400, n);
        `CHK("recovery delay", 1'b1, n >= 300 + TD && n <= 308 + TD)
    endtask

    task t_timeouts;
        int up [4];
        up = '{TGND, TVDD, 4 * CAPU, TGND};
        for (int i = 0; i < 4; i++)
        begin
            restart(i[1:0], 1'b0, 3);
            wait_oen(1'b0, up[i] + 20, n);
            `CHK("timeout", 1'b1, n >= up[i] - 3 && n <= up[i] + 3)
            wait_oen(1'b1, TD + 10, n);
            `CHK("timeout hold", 1'b1, n >= TD - 2 && n <= TD + 2)
        end
    endtask

    task t_window;
        int rat [6];
        int lo;
        rat = '{`SSW_RAT_GND_R0, `SSW_RAT_GND_R1, `SSW_RAT_VDD_R0, `SSW_RAT_VDD_R1,
            `SSW_RAT_CAP_R0, `SSW_RAT_CAP_R1};
        for (int i = 0; i < 6; i++)
        begin
            lo = (i < 2) ? TGND * 10 / rat[i] : (i < 4) ? TVDD * 10 / rat[i]
                : 20 * CAPU * 10 / rat[i];
            restart(i[2:1], i[0], 19);
            kickPeriod <= lo - 8;
            kickEn <= 1'b1;
            hold_oen(lo, "first kick");
            wait_oen(1'b0, lo + 20, n);
            `CHK("early kick", 1'b1, n <= lo)
            kickEn <= 1'b0;
            wait_oen(1'b1, TD + 10, n);
            kickPeriod <= lo + 8;
            kickEn <= 1'b1;
            hold_oen(6 * lo, "window kicks");
        end
    endtask

    // Main sequence
    initial
    begin
        cyc(4);
        t_por;
        t_power_up;
        t_glitch;
        t_timeouts;
        t_window;
        print_verdict;
    end
endmodule
